/* File: core/temp_sense_defines.svh */
/*
   Register offsets, field positions, reset values and timing counts
   for the temperature readout and clock select block.
   Assumes it is included by bare name from the design files.
*/
`ifndef TEMP_SENSE_DEFINES_SVH
`define TEMP_SENSE_DEFINES_SVH

// Byte offsets on the serial register port
`define REG_CTRL_HI          8'h80
`define REG_CTRL_LO          8'h81
`define REG_STATUS           8'h8F
`define REG_TEMP_HI          8'h92
`define REG_TEMP_LO          8'h93
`define REG_REAL_HI          8'h94
`define REG_REAL_LO          8'h95
`define REG_IMAG_HI          8'h96
`define REG_IMAG_LO          8'h97

// Field positions
`define CTRL_CLK_SEL_BIT     3
`define CTRL_CMD_MSB         7
`define CTRL_CMD_LSB         4
`define STAT_TEMP_VALID_BIT  0
`define TEMP_SIGN_BIT        13

// Command codes and reset values
`define CMD_MEASURE_TEMP     4'h9
`define CTRL_HI_RESET        8'h00
`define CTRL_LO_RESET        8'h00

// Timing: conversion time and core clock period
`define CONV_TIME_NS         800000
`define CORE_CLK_PERIOD_NS   5
`define CONV_CYCLES_DEFAULT  ((`CONV_TIME_NS) / (`CORE_CLK_PERIOD_NS))

// Nominal on-chip oscillator rate for behavioural models
`define INT_OSC_FREQ_KHZ     16776

// Serial slave address, value is arbitrary
`define DEV_ADDR_DEFAULT     7'h0D

`endif

/* File: core/temp_sense_pkg.sv */
/*
   Types shared by the temperature readout block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package temp_sense_pkg;

   // Serial slave sequencing states
   typedef enum logic [2:0] {
      ser_idle,
      ser_addr,
      ser_addr_ack,
      ser_wr,
      ser_wr_ack,
      ser_rd,
      ser_rd_ack
   } ser_state_t;

   // Temperature measurement states
   typedef enum logic {
      meas_off,
      meas_conv
   } meas_state_t;

endpackage

/* File: core/temp_sensor_clock_select.sv */
/*
   Two-wire serial register slave, temperature measurement sequencer,
   system clock source select and DFT result holding registers.
   Assumes scl and sda come from pins asynchronous to core_clk, and
   that the sensor front end presents a settled code at conversion end.
*/
`timescale 1ns/1ps
`include "temp_sense_defines.svh"

module temp_sensor_clock_select
   import temp_sense_pkg::*;
#(
   parameter int         CONV_CYCLES = `CONV_CYCLES_DEFAULT,
   parameter logic [6:0] DEV_ADDR    = `DEV_ADDR_DEFAULT
)
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Serial register port
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   // Sensor front end
   input  wire logic [13:0] sensor_code,
   output logic             sensor_pwr,
   // System clock source select
   output logic             clk_sel_ext,
   // DFT engine results
   input  wire logic        dft_valid,
   input  wire logic [15:0] dft_real,
   input  wire logic [15:0] dft_imag
);

   localparam int CNT_W = $clog2(CONV_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and filtering

   logic [2:0]  scl_sync_reg;          // Three-stage scl sampler
   logic [2:0]  sda_sync_reg;          // Three-stage sda sampler
   logic        scl_f_reg;             // Accepted scl level
   logic        sda_f_reg;             // Accepted sda level
   logic        scl_p_reg;             // Previous accepted scl
   logic        sda_p_reg;             // Previous accepted sda
   logic        scl_rise;              // Scl rising edge
   logic        scl_fall;              // Scl falling edge
   logic        bus_start;             // Start condition seen
   logic        bus_stop;              // Stop condition seen

   // Shift pins in; bus idles high
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      end
   end

   // Accept a level once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end
      else
      begin
         if (scl_sync_reg[1] == scl_sync_reg[2])
            scl_f_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2])
            sda_f_reg <= sda_sync_reg[2];
         scl_p_reg <= scl_f_reg;
         sda_p_reg <= sda_f_reg;
      end
   end

   // Bus events from accepted levels
   assign scl_rise  = scl_f_reg && !scl_p_reg;
   assign scl_fall  = !scl_f_reg && scl_p_reg;
   assign bus_start = scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg;
   assign bus_stop  = scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave sequencer

   ser_state_t  ser_state_reg;         // Slave state
   logic [7:0]  shift_reg;             // Receive and transmit shifter
   logic [3:0]  bit_cnt_reg;           // Bits moved in this byte
   logic [7:0]  ptr_reg;               // Register pointer, auto-increments
   logic        ptr_phase_reg;         // Next written byte is the pointer
   logic        rw_reg;                // Read requested in address byte
   logic        mack_reg;              // Master acknowledged read byte
   logic        drive_low_reg;         // Pull sda low
   logic        wr_stb_reg;            // One-cycle register write
   logic [7:0]  wr_addr_reg;           // Register write offset
   logic [7:0]  wr_data_reg;           // Register write data
   logic [7:0]  rd_byte;               // Byte at pointer

   // Byte-wise access of every register over the pins
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ser_state_reg <= ser_idle;
         shift_reg     <= 8'h00;
         bit_cnt_reg   <= 4'h0;
         ptr_reg       <= 8'h00;
         ptr_phase_reg <= 1'b0;
         rw_reg        <= 1'b0;
         mack_reg      <= 1'b0;
         drive_low_reg <= 1'b0;
         wr_stb_reg    <= 1'b0;
         wr_addr_reg   <= 8'h00;
         wr_data_reg   <= 8'h00;
      end
      else
      begin
         wr_stb_reg <= 1'b0;
         if (bus_start)
         begin
            // Start or repeated start
            ser_state_reg <= ser_addr;
            bit_cnt_reg   <= 4'h0;
            drive_low_reg <= 1'b0;
         end
         else if (bus_stop)
         begin
            ser_state_reg <= ser_idle;
            drive_low_reg <= 1'b0;
         end
         else if (scl_rise)
         begin
            // Sample incoming data and master acknowledge
            if (ser_state_reg == ser_addr || ser_state_reg == ser_wr)
            begin
               shift_reg   <= {shift_reg[6:0], sda_f_reg};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (ser_state_reg == ser_rd_ack)
               mack_reg <= !sda_f_reg;
         end
         else if (scl_fall)
         begin
            unique case (ser_state_reg)
               ser_idle: ;
               ser_addr:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     // Answer only our own address
                     if (shift_reg[7:1] == DEV_ADDR)
                     begin
                        ser_state_reg <= ser_addr_ack;
                        rw_reg        <= shift_reg[0];
                        drive_low_reg <= 1'b1;
                     end
                     else
                        ser_state_reg <= ser_idle;
                  end
               ser_addr_ack:
                  if (rw_reg)
                  begin
                     // First read byte from the pointer
                     ser_state_reg <= ser_rd;
                     shift_reg     <= rd_byte;
                     ptr_reg       <= ptr_reg + 8'h01;
                     bit_cnt_reg   <= 4'h0;
                     drive_low_reg <= !rd_byte[7];
                  end
                  else
                  begin
                     ser_state_reg <= ser_wr;
                     bit_cnt_reg   <= 4'h0;
                     ptr_phase_reg <= 1'b1;
                     drive_low_reg <= 1'b0;
                  end
               ser_wr:
                  if (bit_cnt_reg == 4'h8)
                  begin
                     // Pointer byte first, then data to successive offsets
                     ser_state_reg <= ser_wr_ack;
                     drive_low_reg <= 1'b1;
                     ptr_phase_reg <= 1'b0;
                     if (ptr_phase_reg)
                        ptr_reg <= shift_reg;
                     else
                     begin
                        wr_stb_reg  <= 1'b1;
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= shift_reg;
                        ptr_reg     <= ptr_reg + 8'h01;
                     end
                  end
               ser_wr_ack:
               begin
                  ser_state_reg <= ser_wr;
                  bit_cnt_reg   <= 4'h0;
                  drive_low_reg <= 1'b0;
               end
               ser_rd:
                  if (bit_cnt_reg == 4'h7)
                  begin
                     // Release for the master acknowledge
                     ser_state_reg <= ser_rd_ack;
                     drive_low_reg <= 1'b0;
                  end
                  else
                  begin
                     shift_reg     <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg   <= bit_cnt_reg + 4'h1;
                     drive_low_reg <= !shift_reg[6];
                  end
               ser_rd_ack:
                  if (mack_reg)
                  begin
                     ser_state_reg <= ser_rd;
                     shift_reg     <= rd_byte;
                     ptr_reg       <= ptr_reg + 8'h01;
                     bit_cnt_reg   <= 4'h0;
                     drive_low_reg <= !rd_byte[7];
                  end
                  else
                     ser_state_reg <= ser_idle;
               default: ser_state_reg <= ser_idle;
            endcase
         end
      end
   end

   // Open-drain: only ever pulls low
   assign sda_out  = 1'b0;
   assign sda_oe_n = !drive_low_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control register and clock select

   logic [7:0]  ctrl_hi_reg;           // Command byte
   logic [7:0]  ctrl_lo_reg;           // Clock select byte
   logic        ctrl_lo_wr;            // Write to clock select byte
   logic        meas_cmd;              // Measure command written

   assign ctrl_lo_wr = wr_stb_reg && (wr_addr_reg == `REG_CTRL_LO);
   assign meas_cmd   = wr_stb_reg && (wr_addr_reg == `REG_CTRL_HI) &&
      (wr_data_reg[`CTRL_CMD_MSB:`CTRL_CMD_LSB] == `CMD_MEASURE_TEMP);

   // Host-written control bytes; internal oscillator after reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_hi_reg <= `CTRL_HI_RESET;
         ctrl_lo_reg <= `CTRL_LO_RESET;
      end
      else
      begin
         if (wr_stb_reg && wr_addr_reg == `REG_CTRL_HI)
            ctrl_hi_reg <= wr_data_reg;
         if (ctrl_lo_wr)
            ctrl_lo_reg <= wr_data_reg;
      end
   end

   // Low picks the on-chip oscillator, high the external pin
   assign clk_sel_ext = ctrl_lo_reg[`CTRL_CLK_SEL_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Temperature measurement

   meas_state_t meas_state_reg;        // Sensor power state
   logic [CNT_W-1:0] conv_cnt_reg;     // Conversion timer on core clock
   logic        conv_done;             // Last conversion cycle
   logic [13:0] temp_reg;              // Raw signed code, 1/32 degree steps
   logic        temp_valid_reg;        // Valid conversion flag

   assign conv_done = (meas_state_reg == meas_conv) &&
                      (conv_cnt_reg == CNT_W'(CONV_CYCLES - 1));

   // Powered down until commanded; one timed conversion
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meas_state_reg <= meas_off;
         conv_cnt_reg   <= '0;
      end
      else
      begin
         unique case (meas_state_reg)
            meas_off:
               if (meas_cmd)
               begin
                  meas_state_reg <= meas_conv;
                  conv_cnt_reg   <= '0;
               end
            meas_conv:
               if (conv_done)
                  meas_state_reg <= meas_off;
               else
                  conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
         endcase
      end
   end

   assign sensor_pwr = (meas_state_reg == meas_conv);

   // Capture result and flag; start clears the flag
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         temp_reg       <= 14'h0000;
         temp_valid_reg <= 1'b0;
      end
      else if (conv_done)
      begin
         temp_reg       <= sensor_code;
         temp_valid_reg <= 1'b1;
      end
      else if (meas_cmd && meas_state_reg == meas_off)
         temp_valid_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // DFT result holding registers

   logic [15:0] real_reg;              // Real part, twos complement
   logic [15:0] imag_reg;              // Imaginary part, twos complement

   // Latch each completed DFT
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         real_reg <= 16'h0000;
         imag_reg <= 16'h0000;
      end
      else if (dft_valid)
      begin
         real_reg <= dft_real;
         imag_reg <= dft_imag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data mux; result bytes are read-only

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (ptr_reg)
         `REG_CTRL_HI: rd_byte = ctrl_hi_reg;
         `REG_CTRL_LO: rd_byte = ctrl_lo_reg;
         `REG_STATUS:  rd_byte = {7'h00, temp_valid_reg};
         `REG_TEMP_HI: rd_byte = {2'b00, temp_reg[`TEMP_SIGN_BIT:8]};
         `REG_TEMP_LO: rd_byte = temp_reg[7:0];
         `REG_REAL_HI: rd_byte = real_reg[15:8];
         `REG_REAL_LO: rd_byte = real_reg[7:0];
         `REG_IMAG_HI: rd_byte = imag_reg[15:8];
         `REG_IMAG_LO: rd_byte = imag_reg[7:0];
         default:      rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and cover points

   logic        ctrl_lo_seen_reg;      // Clock byte written since reset

   // Helper: remembers any clock select write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_lo_seen_reg <= 1'b0;
      else if (ctrl_lo_wr)
         ctrl_lo_seen_reg <= 1'b1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_clk_sel_follow: assert property (
      ctrl_lo_wr |=> clk_sel_ext == $past(wr_data_reg[`CTRL_CLK_SEL_BIT]))
      else $error("clock select did not follow write");
   a_clk_default_int: assert property (!ctrl_lo_seen_reg |-> !clk_sel_ext)
      else $error("external clock chosen without a write");
   a_meas_start_up: assert property (
      meas_cmd && !sensor_pwr |=> sensor_pwr && !temp_valid_reg)
      else $error("measure command did not start conversion");
   a_busy_cmd_ignored: assert property (
      meas_cmd && sensor_pwr && !conv_done
      |=> conv_cnt_reg == $past(conv_cnt_reg) + CNT_W'(1))
      else $error("command during conversion restarted timer");
   a_conv_end_down: assert property (
      conv_done |=> !sensor_pwr && temp_valid_reg && temp_reg == $past(sensor_code))
      else $error("conversion end not handled");
   a_valid_holds: assert property (temp_valid_reg && !meas_cmd |=> temp_valid_reg)
      else $error("valid flag dropped without new start");
   a_temp_read_only: assert property (!conv_done |=> $stable(temp_reg))
      else $error("temperature changed outside conversion end");
   a_temp_top_zero: assert property (ptr_reg == `REG_TEMP_HI |-> rd_byte[7:6] == 2'b00)
      else $error("temperature don't-care bits not zero");
   a_dft_latch: assert property (
      dft_valid |=> real_reg == $past(dft_real) && imag_reg == $past(dft_imag))
      else $error("DFT result not latched");
   a_idle_release: assert property (ser_state_reg == ser_idle |=> sda_oe_n)
      else $error("sda driven while idle");

   c_meas_done:  cover property (conv_done ##1 temp_valid_reg);
   c_temp_read:  cover property (ser_state_reg == ser_rd && ptr_reg == `REG_TEMP_LO);
   c_clk_ext:    cover property (ctrl_lo_wr ##1 clk_sel_ext);
   c_busy_cmd:   cover property (meas_cmd && sensor_pwr);

endmodule

/* File: verification/serial_host_model.sv */
/*
   Behavioural host controller for the two-wire register port.
   Assumes an open-drain data wire with pull-up resolved by the bench.
*/
`timescale 1ns/1ps

module serial_host_model
#(
   parameter logic [6:0] DEV_ADDR = 7'h0D
)
(
   // Resolved data wire
   input  wire logic sda_wire,
   // Host pin drives
   output logic      scl_pin,
   output logic      sda_drive_n
);
   // Quarter of the 64 ns serial period
   localparam int Q = 16;

   // Bus idles high, clock stands still between frames
   initial
   begin
      scl_pin     = 1'b1;
      sda_drive_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // Bit level: data changes only while the clock is low
   task automatic put_bit(input logic b);
      sda_drive_n = b;
      #Q scl_pin = 1'b1;
      #(2*Q) scl_pin = 1'b0;
      #Q;
   endtask

   // Release the wire and sample it mid-high
   task automatic get_bit(output logic b);
      sda_drive_n = 1'b1;
      #Q scl_pin = 1'b1;
      #Q b = sda_wire;
      #Q scl_pin = 1'b0;
      #Q;
   endtask

   // Start, also usable as a repeated start
   task automatic start_cond();
      sda_drive_n = 1'b1;
      #Q scl_pin = 1'b1;
      #Q sda_drive_n = 1'b0;
      #Q scl_pin = 1'b0;
      #Q;
   endtask

   // Stop, leaves the bus released
   task automatic stop_cond();
      sda_drive_n = 1'b0;
      #Q scl_pin = 1'b1;
      #Q sda_drive_n = 1'b1;
      #(2*Q);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Byte level, MSB first, acknowledge bit returned
   task automatic send_byte(input logic [7:0] d, output logic nack);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(nack);
   endtask

   // Master NACK on the last byte ends the read
   task automatic recv_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask

   // One byte to one location per frame
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data,
                            output logic nack);
      logic n0, n1, n2;
      start_cond();
      send_byte({DEV_ADDR, 1'b0}, n0);
      send_byte(ptr, n1);
      send_byte(data, n2);
      stop_cond();
      nack = n0 | n1 | n2;
   endtask

   // Pointer frame then incrementing read
   task automatic read_regs(input logic [7:0] ptr, input int n,
                            output logic [31:0] d, output logic nack);
      logic       n0, n1, n2;
      logic [7:0] b;
      d = '0;
      start_cond();
      send_byte({DEV_ADDR, 1'b0}, n0);
      send_byte(ptr, n1);
      stop_cond();
      start_cond();
      send_byte({DEV_ADDR, 1'b1}, n2);
      for (int i = 0; i < n; i++)
      begin
         recv_byte(i == n - 1, b);
         d = {d[23:0], b};
      end
      stop_cond();
      nack = n0 | n1 | n2;
   endtask

   // Address probe only, for a foreign slave address
   task automatic probe(input logic [6:0] a, output logic nack);
      start_cond();
      send_byte({a, 1'b1}, nack);
      stop_cond();
   endtask
endmodule

/* File: verification/tb.sv */
/*
   Self-checking bench for the temperature readout and clock select.
   Assumes the host model file is compiled first.
*/
`timescale 1ns/1ps
`include "temp_sense_defines.svh"

module tb;
   // Short conversion so a busy window spans whole frames
   localparam int CONV = 1000;

   logic        core_clk, rst_n, dft_valid;
   logic [13:0] sensor_code;
   logic [15:0] dft_real, dft_imag;
   logic        scl_pin, sda_drive_n, sda_oe_n, sda_out, sensor_pwr, clk_sel_ext;
   wire  logic  sda_wire;
   int          n_mismatch, check_count, pwr_cnt;
   logic [31:0] d;

   // Open-drain wire with pull-up
   assign sda_wire = sda_drive_n & sda_oe_n;

   temp_sensor_clock_select #(.CONV_CYCLES(CONV), .DEV_ADDR(7'h0D))
      temp_sensor_clock_select_inst (.core_clk(core_clk), .rst_n(rst_n),
      .scl_in(scl_pin), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .sensor_code(sensor_code), .sensor_pwr(sensor_pwr), .clk_sel_ext(clk_sel_ext),
      .dft_valid(dft_valid), .dft_real(dft_real), .dft_imag(dft_imag));

   serial_host_model #(.DEV_ADDR(7'h0D)) serial_host_model_inst (.sda_wire(sda_wire),
      .scl_pin(scl_pin), .sda_drive_n(sda_drive_n));

   ////////////////////////////////////////////////////////////////////
   // 200 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Cycles with the sensor powered
   always @(posedge core_clk)
      if (sensor_pwr === 1'b1) pwr_cnt++;

   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Register write, device must acknowledge each byte
   task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
      logic nk;
      @(negedge core_clk);
      serial_host_model_inst.write_reg(ptr, data, nk);
      check("write ack", {31'd0, nk}, 32'd0);
   endtask

   task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] v);
      logic nk;
      @(negedge core_clk);
      serial_host_model_inst.read_regs(ptr, n, v, nk);
      check("read ack", {31'd0, nk}, 32'd0);
   endtask

   // Host side decode in 1/32 degree steps
   function automatic int x32(input logic [13:0] c);
      return c[13] ? int'(c) - 16384 : int'(c);
   endfunction

   // One measurement with a second command while busy
   task automatic measure(input logic [13:0] code, input int exp_x32);
      @(negedge core_clk);
      sensor_code = code;
      pwr_cnt = 0;
      wr(`REG_CTRL_HI, 8'h90);
      rd(`REG_STATUS, 1, d);
      check("valid cleared", d, 32'd0);
      wr(`REG_CTRL_HI, 8'h90);
      for (int i = 0; i < 3 * CONV && sensor_pwr !== 1'b0; i++) @(negedge core_clk);
      check("power cycles", pwr_cnt, CONV);
      rd(`REG_STATUS, 1, d);
      check("valid set", d, 32'h0000_0001);
      rd(`REG_TEMP_HI, 2, d);
      check("temp word", d, {18'd0, code});
      check("temp scale", x32(d[13:0]), exp_x32);
      wr(`REG_TEMP_HI, 8'hFF);
      rd(`REG_TEMP_HI, 2, d);
      check("temp read only", d, {18'd0, code});
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [13:0] rc;
      logic        nk;
      d = $urandom(32'h0000_a340);
      rst_n = 1'b0;
      dft_valid = 1'b0;
      dft_real = '0;
      dft_imag = '0;
      sensor_code = '0;
      n_mismatch = 0;
      check_count = 0;
      pwr_cnt = 0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (10) @(negedge core_clk);
      // Power-up state
      check("pwr at reset", sensor_pwr, 32'd0);
      check("clk sel at reset", clk_sel_ext, 32'd0);
      check("sda idle", sda_oe_n, 32'd1);
      check("sda out low", sda_out, 32'd0);
      rd(`REG_CTRL_HI, 2, d);
      check("ctrl reset", d, 32'd0);
      // Another command code must leave the sensor down
      wr(`REG_CTRL_HI, 8'h10);
      check("no start", sensor_pwr, 32'd0);
      rd(`REG_CTRL_HI, 1, d);
      check("cmd readback", d, 32'h0000_0010);
      // Clock source select both ways
      wr(`REG_CTRL_LO, 8'h08);
      check("clk sel ext", clk_sel_ext, 32'd1);
      rd(`REG_CTRL_LO, 1, d);
      check("ctrl readback", d, 32'h0000_0008);
      wr(`REG_CTRL_LO, 8'h00);
      check("clk sel int", clk_sel_ext, 32'd0);
      // Table corners, then a random code
      measure(14'h3B00, -1280);
      measure(14'h3FFF, -1);
      measure(14'h0320, 800);
      measure(14'h12C0, 4800);
      rc = 14'($urandom);
      measure(rc, x32(rc));
      // Result words: a signed corner, then random
      for (int k = 0; k < 2; k++)
      begin
         @(negedge core_clk);
         dft_real = (k == 0) ? 16'hF064 : 16'($urandom);
         dft_imag = (k == 0) ? 16'h227E : 16'($urandom);
         dft_valid = 1'b1;
         @(negedge core_clk);
         dft_valid = 1'b0;
         rd(`REG_REAL_HI, 4, d);
         check("dft words", d, {dft_real, dft_imag});
      end
      // Unmapped offset and foreign slave address
      rd(8'h90, 1, d);
      check("unmapped read", d, 32'd0);
      @(negedge core_clk);
      serial_host_model_inst.probe(7'h0E, nk);
      check("foreign address", {31'd0, nk}, 32'd1);
      end_of_test();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #400_000;
      n_mismatch++;
      $display("Error watchdog expected done seen timeout");
      end_of_test();
   end
endmodule
